// ---- rtl/bsc_pkg.sv ----
// Package of constants and types for the boot strap capture block.
package bsc_pkg;
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned MSB_SLOW_HZ      = 100_000;
    localparam int unsigned MSB_FAST_HZ      = 400_000;
    localparam int unsigned MSB_SLOW_DIV     = CLK_HZ / MSB_SLOW_HZ;
    localparam int unsigned MSB_FAST_DIV     = CLK_HZ / MSB_FAST_HZ;
    localparam int unsigned DIV_W            = 8;
    localparam int unsigned REF_100_MHZ      = 100;
    localparam int unsigned REF_125_MHZ      = 125;
    localparam int unsigned SER_CLK_MHZ      = 5000;
    localparam int unsigned CORE_CLK_MHZ     = 250;
    localparam logic [2:0]  MODE_NORMAL      = 3'h0;
    localparam logic [2:0]  MODE_NORMAL_EE   = 3'h1;
    localparam logic [2:0]  MODE_RST         = 3'h0;
    // Status vector bit positions.
    localparam int unsigned ST_CCLK_DS       = 0;
    localparam int unsigned ST_CCLK_US       = 1;
    localparam int unsigned ST_MSB_SLOW      = 2;
    localparam int unsigned ST_REF_SEL       = 3;
    localparam int unsigned ST_HALT          = 4;
    localparam int unsigned ST_MODE_LO       = 5;
    localparam int unsigned ST_W             = 8;
    localparam logic [ST_W-1:0] ST_RST       = 8'h00;

    typedef enum logic [2:0] {
        BSC_IDLE  = 3'b001,
        BSC_HALT  = 3'b010,
        BSC_RUN   = 3'b100
    } bsc_state_t;

    typedef struct packed {
        bsc_state_t              state;
        logic                    pin_prev;
        logic                    fund_active;
        logic                    cclk_ds;
        logic                    cclk_us;
        logic                    msb_slow;
        logic                    ref_sel;
        logic                    halt;
        logic [2:0]              mode;
        logic                    slot_ds;
        logic                    slot_us;
        logic [DIV_W-1:0]        div_cnt;
        logic                    msb_tick;
        logic                    core_reset;
        logic                    bypass;
    } bsc_regs_t;
endpackage : bsc_pkg

// ---- rtl/bsc_boot_strap.sv ----
// Boot strap capture, override and clock select for the switch core.
`timescale 1ns/100ps
module bsc_boot_strap
(
    input  wire logic             clock,                 // 25 MHz clock
    input  wire logic             srst,                  // Sync reset
    input  wire logic             external_reset_pin_n,  // Reset pin
    input  wire logic             software_fundamental_reset_bit, // Pulse
    input  wire logic             ref_clock_freq_select, // Strap
    input  wire logic             common_clock_downstream_strap, // Strap
    input  wire logic             common_clock_upstream_strap,   // Strap
    input  wire logic             master_serial_bus_slow_strap,  // Strap
    input  wire logic             reset_halt_strap,      // Strap
    input  wire logic [2:0]       operating_mode_strap,  // Strap
    input  wire logic             pll_bypass_mode_sel,   // Bypass test select
    input  wire logic             ovr_wr,                // Override write
    input  wire logic             ovr_cclk_ds,           // Override value
    input  wire logic             ovr_cclk_us,           // Override value
    input  wire logic             ovr_halt,              // Override value
    input  wire logic             halt_clear,            // Control clears halt
    input  wire logic             slot_ds_wr,            // Software slot write
    input  wire logic             slot_us_wr,            // Software slot write
    input  wire logic             slot_wdata,            // Slot write value
    output logic [bsc_pkg::ST_W-1:0] switch_status_register, // Straps
    output logic                  slot_clock_ds,         // Downstream slot bit
    output logic                  slot_clock_us,         // Upstream slot bit
    output logic                  msb_tick,              // Serial bus rate
    output logic                  core_reset,            // Core held in reset
    output logic                  core_clk_from_ref,     // Bypass selected
    output logic                  eeprom_init_en,        // Mode 1 selected
    output logic                  mode_reserved          // Mode 2 to 7
);
    import bsc_pkg::*;

    bsc_regs_t r_ff;
    bsc_regs_t nxt_r;
    logic      pin_rise;

    always_comb
    begin
        nxt_r    = r_ff;
        pin_rise = external_reset_pin_n && !r_ff.pin_prev;
        nxt_r.pin_prev = external_reset_pin_n;
        if (!external_reset_pin_n || software_fundamental_reset_bit)
        begin
            nxt_r.fund_active = 1'b1;
            nxt_r.state       = BSC_IDLE;
            nxt_r.core_reset  = 1'b1;
        end
        // Straps are only looked at on the pin's negation edge.
        if (pin_rise)
        begin
            nxt_r.cclk_ds  = common_clock_downstream_strap;
            nxt_r.cclk_us  = common_clock_upstream_strap;
            nxt_r.msb_slow = master_serial_bus_slow_strap;
            nxt_r.ref_sel  = ref_clock_freq_select;
            nxt_r.halt     = reset_halt_strap;
            nxt_r.mode     = operating_mode_strap;
            nxt_r.bypass   = pll_bypass_mode_sel;
        end
        // Software reset leaves the captured straps as they are.
        if (r_ff.fund_active && ovr_wr && external_reset_pin_n)
        begin
            nxt_r.cclk_ds = ovr_cclk_ds;
            nxt_r.cclk_us = ovr_cclk_us;
            nxt_r.halt    = ovr_halt;
        end
        // Reset ends one cycle after the capture edge, so that the slot
        // bits and the halt decision see the freshly latched straps.
        if (r_ff.fund_active && external_reset_pin_n && !pin_rise &&
            !software_fundamental_reset_bit && !ovr_wr)
        begin
            nxt_r.fund_active = 1'b0;
            nxt_r.slot_ds     = r_ff.cclk_ds;
            nxt_r.slot_us     = r_ff.cclk_us;
            nxt_r.state       = r_ff.halt ? BSC_HALT : BSC_RUN;
            nxt_r.core_reset  = r_ff.halt;
        end
        unique case (r_ff.state)
            BSC_IDLE: ;
            BSC_HALT:
            begin
                if (halt_clear && !r_ff.fund_active)
                begin
                    // The status halt bit keeps the captured strap value.
                    nxt_r.state      = BSC_RUN;
                    nxt_r.core_reset = 1'b0;
                end
            end
            BSC_RUN: ;
            default:
            begin
                nxt_r.state = BSC_IDLE;
            end
        endcase
        if (!r_ff.fund_active)
        begin
            if (slot_ds_wr)
            begin
                nxt_r.slot_ds = slot_wdata;
            end
            if (slot_us_wr)
            begin
                nxt_r.slot_us = slot_wdata;
            end
        end
        // Serial bus rate tick; divider keeps running so buses stay live.
        nxt_r.msb_tick = 1'b0;
        if (r_ff.div_cnt == 8'h00)
        begin
            nxt_r.msb_tick = 1'b1;
            nxt_r.div_cnt  = r_ff.msb_slow ? DIV_W'(MSB_SLOW_DIV - 1)
                                           : DIV_W'(MSB_FAST_DIV - 1);
        end
        else
        begin
            nxt_r.div_cnt = r_ff.div_cnt - 8'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            r_ff            <= '0;
            r_ff.state      <= BSC_IDLE;
            r_ff.pin_prev   <= 1'b1;
            r_ff.core_reset <= 1'b1;
            r_ff.mode       <= MODE_RST;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    always_comb
    begin
        switch_status_register                = ST_RST;
        switch_status_register[ST_CCLK_DS]    = r_ff.cclk_ds;
        switch_status_register[ST_CCLK_US]    = r_ff.cclk_us;
        switch_status_register[ST_MSB_SLOW]   = r_ff.msb_slow;
        switch_status_register[ST_REF_SEL]    = r_ff.ref_sel;
        switch_status_register[ST_HALT]       = r_ff.halt;
        switch_status_register[ST_MODE_LO+:3] = r_ff.mode;
    end

    assign slot_clock_ds     = r_ff.slot_ds;
    assign slot_clock_us     = r_ff.slot_us;
    assign msb_tick          = r_ff.msb_tick;
    // Without bypass the core follows the 250 MHz upstream PLL clock.
    // PLL lane clocks are analog and outside this logic.
    assign core_reset        = r_ff.core_reset;
    assign core_clk_from_ref = r_ff.bypass;
    assign eeprom_init_en    = (r_ff.mode == MODE_NORMAL_EE);
    assign mode_reserved     = (r_ff.mode != MODE_NORMAL) &&
                               (r_ff.mode != MODE_NORMAL_EE);

    a_halt_holds: assert property (
        @(posedge clock) disable iff (srst)
        (r_ff.state == BSC_HALT && !halt_clear) |=> core_reset)
        else $error("halt state left without clear");
    a_halt_exit: assert property (
        @(posedge clock) disable iff (srst)
        $fell(core_reset) |-> $past(halt_clear) || !$past(r_ff.halt))
        else $error("core reset released without halt clear");
    a_strap_ignore: assert property (
        @(posedge clock) disable iff (srst)
        (!pin_rise && !(r_ff.fund_active && ovr_wr)) |=>
        $stable(switch_status_register))
        else $error("status changed outside capture");
    a_strap_capture: assert property (
        @(posedge clock) disable iff (srst)
        (pin_rise && !ovr_wr) |=>
        switch_status_register[ST_REF_SEL] == $past(ref_clock_freq_select))
        else $error("reference select not captured");
    a_sw_reuse: assert property (
        @(posedge clock) disable iff (srst)
        (software_fundamental_reset_bit && external_reset_pin_n &&
         r_ff.pin_prev && !ovr_wr) |=>
        $stable(switch_status_register[ST_MODE_LO+:3]))
        else $error("software reset resampled straps");
    a_tick_rate: assert property (
        @(posedge clock) disable iff (srst)
        (msb_tick && r_ff.msb_slow && $stable(r_ff.msb_slow)) |=>
        !msb_tick[*8])
        else $error("serial bus tick too fast");
    a_mode_dec: assert property (
        @(posedge clock) disable iff (srst)
        eeprom_init_en |-> !mode_reserved && r_ff.mode == 3'h1)
        else $error("mode decode wrong");
    a_slot_init: assert property (
        @(posedge clock) disable iff (srst)
        $fell(r_ff.fund_active) |-> slot_clock_ds == r_ff.cclk_ds &&
        slot_clock_us == r_ff.cclk_us)
        else $error("slot clock bit not loaded from strap");
    // Overrides arriving after reset has ended must leave status alone.
    a_ovr_refused: assert property (
        @(posedge clock) disable iff (srst)
        (!r_ff.fund_active && ovr_wr && !pin_rise) |=>
        $stable(switch_status_register))
        else $error("override taken outside reset");
    a_bypass_hold: assert property (
        @(posedge clock) disable iff (srst)
        !pin_rise |=> $stable(core_clk_from_ref))
        else $error("core clock source moved outside capture");
    a_slot_write: assert property (
        @(posedge clock) disable iff (srst)
        (!r_ff.fund_active && slot_ds_wr) |=>
        slot_clock_ds == $past(slot_wdata))
        else $error("software slot write lost");
    a_halt_entry: assert property (
        @(posedge clock) disable iff (srst)
        $fell(r_ff.fund_active) |-> core_reset == r_ff.halt)
        else $error("core reset does not follow halt at reset end");
endmodule : bsc_boot_strap

// ---- bench/bsc_board.sv ----
// Board model: reset pin source and strap pins of the capture block.
`timescale 1ns/100ps
module bsc_board #(
    parameter int RST_CYC = 20
) (
    input  wire logic       clock,         // Bench clock
    input  wire logic       srst,          // Holds the pin asserted
    input  wire logic       go,            // Starts one pin reset
    input  wire logic [7:0] cfg,           // Straps while the pin is low
    output logic            pin_n,         // Reset pin, low active
    output logic [7:0]      straps         // {mode,halt,ref,slow,us,ds}
);
    int cnt;
    always_ff @(posedge clock)
    begin
        if (srst || go)
            cnt <= RST_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
        pin_n <= !(srst || go || cnt > 1);
        // Jumpers move one cycle after the pin rises, so a late grab shows.
        straps <= pin_n ? ~cfg : cfg;
    end
endmodule : bsc_board

// ---- bench/tb.sv ----
// Self-checking bench for the boot strap capture block.
`timescale 1ns/100ps
module tb;
    import bsc_pkg::*;
    localparam int RST_CYC = 20;
    logic       clock = 1'b0, srst = 1'b1, go = 1'b0, sw = 1'b0;
    logic       byp = 1'b0, ow = 1'b0, ods = 1'b0, ous = 1'b0;
    logic       oh = 1'b0, hc = 1'b0, sdw = 1'b0, suw = 1'b0, sd = 1'b0;
    logic [7:0] cfg = 8'h00, st, sts;
    logic       pin_n, s_ds, s_us, tick, c_rst, f_ref, ee, rsv;
    int         err_total = 0, samples_checked = 0, cycles = 0;

    bsc_board #(.RST_CYC(RST_CYC)) i_bsc_board (.clock(clock),
        .srst(srst), .go(go), .cfg(cfg), .pin_n(pin_n), .straps(st));
    bsc_boot_strap i_bsc_boot_strap (.clock(clock), .srst(srst),
        .external_reset_pin_n(pin_n), .software_fundamental_reset_bit(sw),
        .ref_clock_freq_select(st[3]), .common_clock_downstream_strap(st[0]),
        .common_clock_upstream_strap(st[1]),
        .master_serial_bus_slow_strap(st[2]), .reset_halt_strap(st[4]),
        .operating_mode_strap(st[7:5]), .pll_bypass_mode_sel(byp),
        .ovr_wr(ow), .ovr_cclk_ds(ods), .ovr_cclk_us(ous), .ovr_halt(oh),
        .halt_clear(hc), .slot_ds_wr(sdw), .slot_us_wr(suw),
        .slot_wdata(sd), .switch_status_register(sts),
        .slot_clock_ds(s_ds), .slot_clock_us(s_us), .msb_tick(tick),
        .core_reset(c_rst), .core_clk_from_ref(f_ref),
        .eeprom_init_en(ee), .mode_reserved(rsv));

    always #20 clock = ~clock;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic capture(input logic [7:0] v, input logic b);
        @(posedge clock);
        cfg <= v;
        byp <= b;
        go  <= 1'b1;
        @(posedge clock) go <= 1'b0;
        repeat (RST_CYC + 4) @(posedge clock);
        @(negedge clock);
    endtask : capture

    // Cycles between two serial bus ticks; 300 bounds a dead divider.
    task automatic period(output int n);
        for (n = 0; n < 300 && tick !== 1'b1; n++) @(negedge clock);
        @(negedge clock);
        for (n = 1; n < 300 && tick !== 1'b1; n++) @(negedge clock);
    endtask : period

    task automatic t_capture_modes();
        int         n;
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v = {i[2:0], i[0], i[1], ~i[1], i[2], ~i[0]};
            capture(v, i[1]);
            chk(sts, v);
            chk({s_us, s_ds}, v[1:0]);
            chk({rsv, ee}, {i > 1, i == 1});
            chk(f_ref, i[1]);
            chk(c_rst, v[4]);
            period(n);
            chk(n[7:0], v[2] ? 8'hfa : 8'h3e);
            chk(sts, v);
            @(posedge clock) hc <= 1'b1;
            @(posedge clock) hc <= 1'b0;
            @(negedge clock) chk(c_rst, 1'b0);
        end
        $display("done capture and modes");
    endtask : t_capture_modes

    task automatic t_sw_reset();
        @(posedge clock) sw <= 1'b1;
        @(posedge clock) sw <= 1'b0;
        repeat (6) @(negedge clock);
        chk(sts, cfg);
        chk(c_rst, cfg[4]);
        $display("done software reset");
    endtask : t_sw_reset

    task automatic t_override();
        logic [7:0] e;
        e = {cfg[7:5], 1'b0, cfg[3:2], ~cfg[1:0]};
        @(posedge clock);
        {sw, ods, ous, oh} <= {1'b1, ~cfg[0], ~cfg[1], 1'b0};
        @(posedge clock) {sw, ow} <= 2'b01;
        @(posedge clock) ow <= 1'b0;
        repeat (6) @(negedge clock);
        chk(sts, e);
        chk(c_rst, 1'b0);
        @(posedge clock) {ow, ods} <= {1'b1, cfg[0]};
        @(posedge clock) ow <= 1'b0;
        repeat (3) @(negedge clock);
        chk(sts, e);
        $display("done override");
    endtask : t_override

    task automatic t_slot_write();
        logic [1:0] e;
        e = ~{s_us, s_ds};
        @(posedge clock) {sdw, sd} <= {1'b1, e[0]};
        @(posedge clock) {sdw, suw, sd} <= {2'b01, e[1]};
        @(posedge clock) suw <= 1'b0;
        @(negedge clock) chk({s_us, s_ds}, e);
        $display("done slot write");
    endtask : t_slot_write

    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        repeat (RST_CYC + 4) @(negedge clock);
        t_capture_modes();
        t_sw_reset();
        t_override();
        t_slot_write();
        end_sim();
    end
endmodule : tb
